// ---- design/pcc_fix_cnt.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Loadable up-counter with wrap pulse
// ---------------------------------------------------------------
module pcc_fix_cnt import pcc_pkg::*; #(
  parameter int CNT_W = 48
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic inc_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  // Status
  output logic [CNT_W-1:0] count_o,
  output logic wrap_o
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Software load wins over a same-cycle event
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = load_val_i;
    end else if (inc_i) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_o = cnt_r;
  // Wrap from all ones to zero
  assign wrap_o = inc_i && !load_i && (&cnt_r);

endmodule : pcc_fix_cnt

// ---- design/pcc_irq.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Sticky event status, mask and interrupt line
// ---------------------------------------------------------------
module pcc_irq import pcc_pkg::*; #(
  parameter int EV_N = PCC_EV_N
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Events and software access
  input wire logic [EV_N-1:0] event_i,
  input wire logic stat_rd_i,
  input wire logic mask_wr_i,
  input wire logic [EV_N-1:0] mask_wdata_i,
  // Status
  output logic [EV_N-1:0] stat_o,
  output logic [EV_N-1:0] mask_o,
  output logic irq_o
);

  logic [EV_N-1:0] stat_r;
  logic [EV_N-1:0] stat_nxt;
  logic [EV_N-1:0] mask_r;
  logic [EV_N-1:0] mask_nxt;

  // Read clears, but an event in the same cycle stays set
  always_comb begin
    stat_nxt = stat_rd_i ? event_i : (stat_r | event_i);
    mask_nxt = mask_wr_i ? mask_wdata_i : mask_r;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign stat_o = stat_r;
  assign mask_o = mask_r;
  assign irq_o = |(stat_r & mask_r);

endmodule : pcc_irq

// ---- design/pcc_pkg.sv ----
// ---------------------------------------------------------------
// Register map and field layout
// ---------------------------------------------------------------
package pcc_pkg;

  // Bus widths
  localparam int PCC_ADDR_W = 16;
  localparam int PCC_DATA_W = 64;

  // Register offsets
  localparam logic [15:0] PCC_FIX2_CNT_ADDR = 16'h030b;
  localparam logic [15:0] PCC_FIX_CTRL_ADDR = 16'h038d;
  localparam logic [15:0] PCC_GLB_STAT_ADDR = 16'h038e;
  localparam logic [15:0] PCC_GLB_EN_ADDR = 16'h038f;
  localparam logic [15:0] PCC_OVF_CLR_ADDR = 16'h0390;
  localparam logic [15:0] PCC_IRQ_STAT_ADDR = 16'h03a0;
  localparam logic [15:0] PCC_IRQ_MASK_ADDR = 16'h03a1;

  // Fixed-counter control fields for counter 2
  localparam int PCC_FC2_KERN_BIT = 8;
  localparam int PCC_FC2_PMI_BIT = 11;
  localparam int PCC_FC2_W = 4;

  // Global status and enable bit positions
  localparam int PCC_GP_N = 4;
  localparam int PCC_ST_FIX0_BIT = 32;
  localparam int PCC_ST_FIX2_BIT = 34;
  localparam int PCC_EN_FIX2_BIT = 34;

  // Interrupt event positions
  localparam int PCC_EV_FIX2 = 0;
  localparam int PCC_EV_GP0 = 1;
  localparam int PCC_EV_FIX0 = 5;
  localparam int PCC_EV_N = 6;

  // Privilege level that counts as kernel
  localparam logic [1:0] PCC_KERNEL_CPL = 2'h0;

  // Reset values
  localparam logic [PCC_DATA_W-1:0] PCC_ZERO64 = 64'h0;

  // Fixed counter 2 controls, same order as bits 11..8
  typedef struct packed {
    logic perf_monitor_interrupt;
    logic any;
    logic user;
    logic kern;
  } pcc_fix2_ctl_t;

  // One register-bus request
  typedef struct packed {
    logic [PCC_ADDR_W-1:0] addr;
    logic [PCC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pcc_bus_req_t;

  // Privilege qualification of a fixed-counter event
  function automatic logic pcc_priv_match(input pcc_fix2_ctl_t ctl,
                                          input logic [1:0] current_privilege_level);
    pcc_priv_match = (ctl.kern && (current_privilege_level == PCC_KERNEL_CPL)) ||
                     (ctl.user && (current_privilege_level != PCC_KERNEL_CPL));
  endfunction : pcc_priv_match

endpackage : pcc_pkg

// ---- design/pcc_top.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Fixed counter 2 control and global overflow status
// ---------------------------------------------------------------
// Behaviour
// R1: Counter 2 counts by privilege enable bits
// R2: Cross-thread select widens counted event sources
// R3: Counter 2 overflow interrupt gated by enable
// R4: Global status read-only, bits 0-3 general
// R5: General flags 2,3 only on one model
// R6: Bit 32 fixed0 overflow, version above one
// R7: Count needs global and privilege enables
// R8: Writing one to clear register clears flag
// R9: Flag set on wrap, held until cleared
module pcc_top import pcc_pkg::*; #(
  parameter int CNT_W = 48,
  parameter int NTHR = 2,
  parameter int TW = 1,
  parameter bit HAS_GP23 = 1'b1,
  parameter int PERF_VERSION = 2
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [PCC_ADDR_W-1:0] addr_i,
  input wire logic [PCC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [PCC_DATA_W-1:0] rdata_o,
  // Core events
  input wire logic [1:0] current_privilege_level_i,
  input wire logic [NTHR-1:0] fix2_event_i,
  input wire logic [TW-1:0] own_thread_i,
  input wire logic [PCC_GP_N-1:0] gp_wrap_i,
  input wire logic fix0_wrap_i,
  // Interrupts
  output logic perf_monitor_interrupt_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pcc_bus_req_t req;
  pcc_fix2_ctl_t fix2_ctl_r;
  pcc_fix2_ctl_t fix2_ctl_nxt;
  logic glb_en_r;
  logic glb_en_nxt;
  logic [PCC_GP_N-1:0] gp_ovf_r;
  logic [PCC_GP_N-1:0] gp_ovf_nxt;
  logic fix0_ovf_r;
  logic fix0_ovf_nxt;
  logic fix2_ovf_r;
  logic fix2_ovf_nxt;
  logic [PCC_DATA_W-1:0] rdata_r;
  logic [PCC_DATA_W-1:0] rdata_nxt;
  logic [PCC_GP_N-1:0] gp_present;
  logic fix0_present;
  logic own_event;
  logic any_event;
  logic thread_event;
  logic fix2_inc;
  logic fix2_wrap;
  logic [CNT_W-1:0] fix2_count;
  logic cnt_wr;
  logic clr_wr;
  logic [PCC_DATA_W-1:0] status_word;
  logic [PCC_EV_N-1:0] irq_events;
  logic [PCC_EV_N-1:0] irq_stat;
  logic [PCC_EV_N-1:0] irq_mask;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ---------------------------------------------------------------
  // Model and version dependent flags
  // ---------------------------------------------------------------
  // Flags 2 and 3 tie off on models without the extra counters
  assign gp_present = {HAS_GP23, HAS_GP23, 1'b1, 1'b1}; // R5
  assign fix0_present = (PERF_VERSION > 1); // R6

  // ---------------------------------------------------------------
  // Fixed counter 2 qualification
  // ---------------------------------------------------------------
  // Any-thread collapses simultaneous events to one step per cycle;
  // an exact multi-thread sum would need an adder per thread.
  assign own_event = fix2_event_i[own_thread_i];
  assign any_event = |fix2_event_i;
  assign thread_event = fix2_ctl_r.any ? any_event : own_event; // R2
  assign fix2_inc = thread_event && glb_en_r && // R7
                    pcc_priv_match(fix2_ctl_r,
                                   current_privilege_level_i); // R1
  assign cnt_wr = req.wr && (req.addr == PCC_FIX2_CNT_ADDR);

  pcc_fix_cnt #(
    .CNT_W(CNT_W)
  ) u_fix2_cnt (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .inc_i(fix2_inc),
    .load_i(cnt_wr),
    .load_val_i(req.wdata[CNT_W-1:0]),
    .count_o(fix2_count),
    .wrap_o(fix2_wrap)
  );

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Only the counter 2 fields live here; other bits read zero
  always_comb begin
    fix2_ctl_nxt = fix2_ctl_r;
    glb_en_nxt = glb_en_r;
    if (req.wr && (req.addr == PCC_FIX_CTRL_ADDR)) begin
      fix2_ctl_nxt = pcc_fix2_ctl_t'(
        req.wdata[PCC_FC2_PMI_BIT:PCC_FC2_KERN_BIT]);
    end
    if (req.wr && (req.addr == PCC_GLB_EN_ADDR)) begin
      glb_en_nxt = req.wdata[PCC_EN_FIX2_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fix2_ctl_r <= '0;
      glb_en_r <= 1'b0;
    end else begin
      fix2_ctl_r <= fix2_ctl_nxt;
      glb_en_r <= glb_en_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Overflow flags
  // ---------------------------------------------------------------
  // Status itself ignores writes; only the clear register acts,
  // and a wrap in the clearing cycle keeps its flag set.
  assign clr_wr = req.wr && (req.addr == PCC_OVF_CLR_ADDR);

  always_comb begin
    gp_ovf_nxt = gp_ovf_r;
    fix0_ovf_nxt = fix0_ovf_r;
    fix2_ovf_nxt = fix2_ovf_r;
    if (clr_wr) begin
      gp_ovf_nxt = gp_ovf_r & ~req.wdata[PCC_GP_N-1:0]; // R8
      fix0_ovf_nxt = fix0_ovf_r & ~req.wdata[PCC_ST_FIX0_BIT];
      fix2_ovf_nxt = fix2_ovf_r & ~req.wdata[PCC_ST_FIX2_BIT];
    end
    gp_ovf_nxt = (gp_ovf_nxt | gp_wrap_i) & gp_present; // R9
    fix0_ovf_nxt = (fix0_ovf_nxt | fix0_wrap_i) & fix0_present;
    fix2_ovf_nxt = fix2_ovf_nxt | fix2_wrap; // R9
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gp_ovf_r <= '0;
      fix0_ovf_r <= 1'b0;
      fix2_ovf_r <= 1'b0;
    end else begin
      gp_ovf_r <= gp_ovf_nxt;
      fix0_ovf_r <= fix0_ovf_nxt;
      fix2_ovf_r <= fix2_ovf_nxt;
    end
  end

  // Status word, reserved bits zero
  always_comb begin
    status_word = PCC_ZERO64;
    status_word[PCC_GP_N-1:0] = gp_ovf_r; // R4
    status_word[PCC_ST_FIX0_BIT] = fix0_ovf_r; // R6
    status_word[PCC_ST_FIX2_BIT] = fix2_ovf_r;
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Counter 2 overflow interrupts only with its enable set
  assign perf_monitor_interrupt_o = fix2_ovf_r && fix2_ctl_r.perf_monitor_interrupt; // R3
  assign irq_events[PCC_EV_FIX2] = fix2_wrap && fix2_ctl_r.perf_monitor_interrupt; // R3
  assign irq_events[PCC_EV_FIX0-1:PCC_EV_GP0] = gp_wrap_i & gp_present;
  assign irq_events[PCC_EV_FIX0] = fix0_wrap_i && fix0_present;

  pcc_irq #(
    .EV_N(PCC_EV_N)
  ) u_irq (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(irq_events),
    .stat_rd_i(req.rd && (req.addr == PCC_IRQ_STAT_ADDR)),
    .mask_wr_i(req.wr && (req.addr == PCC_IRQ_MASK_ADDR)),
    .mask_wdata_i(req.wdata[PCC_EV_N-1:0]),
    .stat_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Data valid only in the cycle after the read strobe
  always_comb begin
    rdata_nxt = PCC_ZERO64;
    if (!req.rd) begin
      rdata_nxt = PCC_ZERO64;
    end else if (req.addr == PCC_FIX2_CNT_ADDR) begin
      rdata_nxt[CNT_W-1:0] = fix2_count;
    end else if (req.addr == PCC_FIX_CTRL_ADDR) begin
      rdata_nxt[PCC_FC2_PMI_BIT:PCC_FC2_KERN_BIT] = fix2_ctl_r;
    end else if (req.addr == PCC_GLB_STAT_ADDR) begin
      rdata_nxt = status_word; // R4
    end else if (req.addr == PCC_GLB_EN_ADDR) begin
      rdata_nxt[PCC_EN_FIX2_BIT] = glb_en_r;
    end else if (req.addr == PCC_IRQ_STAT_ADDR) begin
      rdata_nxt[PCC_EV_N-1:0] = irq_stat;
    end else if (req.addr == PCC_IRQ_MASK_ADDR) begin
      rdata_nxt[PCC_EV_N-1:0] = irq_mask;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_user_gate: assert property ( // R1
    (current_privilege_level_i != PCC_KERNEL_CPL && !fix2_ctl_r.user)
    |-> !fix2_inc)
    else $error("counter 2 counted in user mode while disabled");

  a_kernel_step: assert property ( // R1
    (own_event && glb_en_r && fix2_ctl_r.kern && !cnt_wr &&
     current_privilege_level_i == PCC_KERNEL_CPL)
    |=> fix2_count == CNT_W'($past(fix2_count) + 1'b1))
    else $error("counter 2 missed a kernel event");

  a_thread_sel: assert property ( // R2
    (!fix2_ctl_r.any && !own_event) |-> !fix2_inc)
    else $error("counter 2 counted another thread's event");

  a_cross_step: assert property ( // R2
    (fix2_ctl_r.any && any_event && glb_en_r && fix2_ctl_r.user &&
     !cnt_wr && current_privilege_level_i != PCC_KERNEL_CPL)
    |=> fix2_count == CNT_W'($past(fix2_count) + 1'b1))
    else $error("counter 2 missed a cross-thread event");

  a_pmi_raise: assert property ( // R3
    (fix2_wrap && fix2_ctl_r.perf_monitor_interrupt && fix2_ctl_nxt.perf_monitor_interrupt)
    |=> perf_monitor_interrupt_o)
    else $error("no interrupt after counter 2 overflow");

  a_pmi_quiet: assert property ( // R3
    !fix2_ctl_r.perf_monitor_interrupt |-> !perf_monitor_interrupt_o)
    else $error("interrupt raised with its enable clear");

  a_status_ro: assert property ( // R4
    (req.wr && req.addr == PCC_GLB_STAT_ADDR)
    |=> (status_word & $past(status_word)) == $past(status_word))
    else $error("write to status changed a flag");

  a_gp23_absent: assert property ( // R5
    !HAS_GP23 |-> gp_ovf_r[PCC_GP_N-1:2] == 2'h0)
    else $error("absent general flags set");

  a_fix0_absent: assert property ( // R6
    (PERF_VERSION <= 1) |-> !status_word[PCC_ST_FIX0_BIT])
    else $error("fixed 0 flag set on early version");

  a_glb_gate: assert property ( // R7
    (!glb_en_r && !cnt_wr) |=> $stable(fix2_count))
    else $error("counter 2 advanced with global enable clear");

  a_clear_one: assert property ( // R8
    (clr_wr && req.wdata[0] && !gp_wrap_i[0]) |=> !gp_ovf_r[0])
    else $error("clear write left flag set");

  a_fix0_clear: assert property ( // R8
    (clr_wr && req.wdata[PCC_ST_FIX0_BIT] && !fix0_wrap_i)
    |=> !fix0_ovf_r)
    else $error("clear write left fixed 0 flag set");

  a_gp_set: assert property ( // R9
    gp_wrap_i[0] |=> gp_ovf_r[0])
    else $error("general wrap did not set its flag");

  a_flag_sticky: assert property ( // R9
    (fix2_ovf_r && !(clr_wr && req.wdata[PCC_ST_FIX2_BIT]))
    |=> fix2_ovf_r [*1] ##0 $past(fix2_ovf_r))
    else $error("overflow flag dropped without clear");

  a_wrap_sets: assert property ( // R9
    fix2_wrap |=> fix2_ovf_r && fix2_count == '0 || cnt_wr)
    else $error("wrap did not set the flag");

  a_read_late: assert property ( // R4
    (req.rd && req.addr == PCC_GLB_STAT_ADDR)
    |=> rdata_o == $past(status_word))
    else $error("status read data wrong");

endmodule : pcc_top

// ---- tb/pcc_top_tb_top.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Bench for fixed counter 2 control and overflow status
// ---------------------------------------------------------------
module pcc_top_tb_top;
  import pcc_pkg::*;

  // One ordinary counting case: control nibble, privilege, events
  typedef struct packed {
    logic [3:0] ctl;
    logic [1:0] current_privilege_level;
    logic [1:0] ev;
    logic en;
    logic inc;
  } pcc_row_t;

  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [PCC_ADDR_W-1:0] addr_i = '0;
  logic [PCC_DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [PCC_DATA_W-1:0] rdata_o;
  logic [PCC_DATA_W-1:0] rdata_alt;
  logic [1:0] current_privilege_level_i = 2'h0;
  logic [1:0] fix2_event_i = 2'h0;
  logic [0:0] own_thread_i = 1'h0;
  logic [PCC_GP_N-1:0] gp_wrap_i = '0;
  logic fix0_wrap_i = 1'b0;
  logic perf_monitor_interrupt_o;
  logic irq_o;
  int err_total = 0;
  int comparisons = 0;
  pcc_row_t rows [8] = '{
    '{4'h1, 2'h0, 2'h1, 1'b1, 1'b1},
    '{4'h1, 2'h3, 2'h1, 1'b1, 1'b0},
    '{4'h2, 2'h2, 2'h1, 1'b1, 1'b1},
    '{4'h2, 2'h0, 2'h1, 1'b1, 1'b0},
    '{4'h3, 2'h1, 2'h2, 1'b1, 1'b0},
    '{4'h7, 2'h1, 2'h2, 1'b1, 1'b1},
    '{4'h7, 2'h0, 2'h3, 1'b1, 1'b1},
    '{4'h3, 2'h0, 2'h1, 1'b0, 1'b0}
  };

  // 100 ns period
  always #50 mclk_i = ~mclk_i;

  pcc_top dut_u (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .current_privilege_level_i(current_privilege_level_i),
    .fix2_event_i(fix2_event_i),
    .own_thread_i(own_thread_i),
    .gp_wrap_i(gp_wrap_i),
    .fix0_wrap_i(fix0_wrap_i),
    .perf_monitor_interrupt_o(perf_monitor_interrupt_o),
    .irq_o(irq_o)
  );

  // Model without general flags 2, 3 and without fixed 0 flag
  pcc_top #(
    .HAS_GP23(1'b0),
    .PERF_VERSION(1)
  ) dut_alt_u (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_alt),
    .current_privilege_level_i(current_privilege_level_i),
    .fix2_event_i(fix2_event_i),
    .own_thread_i(own_thread_i),
    .gp_wrap_i(gp_wrap_i),
    .fix0_wrap_i(fix0_wrap_i),
    .perf_monitor_interrupt_o(),
    .irq_o()
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data only stand in the cycle after the strobe
  task automatic rd(input string n, input logic [15:0] a,
                    input logic [63:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, e, rdata_o);
  endtask : rd

  // One-cycle event pulses
  task automatic pulse(input logic [1:0] ev, input logic [3:0] gp,
                       input logic f0);
    @(posedge mclk_i);
    fix2_event_i <= ev;
    gp_wrap_i <= gp;
    fix0_wrap_i <= f0;
    @(posedge mclk_i);
    fix2_event_i <= 2'h0;
    gp_wrap_i <= 4'h0;
    fix0_wrap_i <= 1'b0;
  endtask : pulse

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog: the tests need well under 2000 cycles
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd("status_rst", PCC_GLB_STAT_ADDR, 64'h0);
    rd("ctrl_rst", PCC_FIX_CTRL_ADDR, 64'h0);
    chk("irq_rst", 64'h0, {63'h0, irq_o | perf_monitor_interrupt_o});
    // Table of privilege, thread and enable cases
    foreach (rows[i]) begin
      wr(PCC_FIX_CTRL_ADDR, ~64'h0f00 | (64'(rows[i].ctl) << 8));
      rd("ctrl_rb", PCC_FIX_CTRL_ADDR, 64'(rows[i].ctl) << 8);
      wr(PCC_GLB_EN_ADDR, 64'(rows[i].en) << PCC_EN_FIX2_BIT);
      wr(PCC_FIX2_CNT_ADDR, 64'h5);
      @(posedge mclk_i);
      current_privilege_level_i <= rows[i].current_privilege_level;
      pulse(rows[i].ev, 4'h0, 1'b0);
      rd("fix2_count", PCC_FIX2_CNT_ADDR, 64'h5 + rows[i].inc);
    end
    // Other thread as the programming one; last row left enable off
    wr(PCC_GLB_EN_ADDR, 64'h1 << PCC_EN_FIX2_BIT);
    wr(PCC_FIX_CTRL_ADDR, 64'h100);
    wr(PCC_FIX2_CNT_ADDR, 64'h5);
    own_thread_i <= 1'h1;
    pulse(2'h2, 4'h0, 1'b0);
    rd("own_thr1", PCC_FIX2_CNT_ADDR, 64'h6);
    pulse(2'h1, 4'h0, 1'b0);
    rd("other_thr0", PCC_FIX2_CNT_ADDR, 64'h6);
    @(posedge mclk_i);
    own_thread_i <= 1'h0;
    // Wrap of counter 2 with its interrupt enabled
    wr(PCC_FIX_CTRL_ADDR, 64'hb00);
    wr(PCC_FIX2_CNT_ADDR, 64'hffff_ffff_ffff);
    current_privilege_level_i <= 2'h0;
    pulse(2'h1, 4'h0, 1'b0);
    rd("fix2_wrap", PCC_FIX2_CNT_ADDR, 64'h0);
    rd("st_fix2", PCC_GLB_STAT_ADDR, 64'h1 << PCC_ST_FIX2_BIT);
    chk("pmi_on", 64'h1, {63'h0, perf_monitor_interrupt_o});
    chk("irq_masked", 64'h0, {63'h0, irq_o});
    wr(PCC_FIX_CTRL_ADDR, 64'h100);
    #1;
    chk("pmi_off", 64'h0, {63'h0, perf_monitor_interrupt_o});
    rd("irq_st", PCC_IRQ_STAT_ADDR, 64'h1);
    rd("irq_st_clr", PCC_IRQ_STAT_ADDR, 64'h0);
    // Writing zero leaves the flag, writing one clears it
    wr(PCC_OVF_CLR_ADDR, 64'h0);
    rd("st_keep", PCC_GLB_STAT_ADDR, 64'h1 << PCC_ST_FIX2_BIT);
    wr(PCC_OVF_CLR_ADDR, 64'h1 << PCC_ST_FIX2_BIT);
    rd("st_clr", PCC_GLB_STAT_ADDR, 64'h0);
    // Wrap of counter 2 with its interrupt disabled
    wr(PCC_FIX2_CNT_ADDR, 64'hffff_ffff_ffff);
    pulse(2'h1, 4'h0, 1'b0);
    rd("irq_no_pmi", PCC_IRQ_STAT_ADDR, 64'h0);
    wr(PCC_OVF_CLR_ADDR, 64'h1 << PCC_ST_FIX2_BIT);
    // General and fixed-0 flags, masked interrupt line
    wr(PCC_IRQ_MASK_ADDR, 64'h3f);
    rd("mask_rb", PCC_IRQ_MASK_ADDR, 64'h3f);
    pulse(2'h0, 4'hf, 1'b1);
    #1;
    chk("irq_on", 64'h1, {63'h0, irq_o});
    repeat (5) @(posedge mclk_i);
    rd("st_gp", PCC_GLB_STAT_ADDR, 64'h1_0000_000f);
    chk("st_gp_alt", 64'h3, rdata_alt);
    wr(PCC_GLB_STAT_ADDR, 64'h0);
    rd("st_ro", PCC_GLB_STAT_ADDR, 64'h1_0000_000f);
    // Read data stand for one cycle only
    @(posedge mclk_i);
    #1;
    chk("rdata_drop", 64'h0, rdata_o);
    rd("irq_gp", PCC_IRQ_STAT_ADDR, 64'h3e);
    chk("irq_off", 64'h0, {63'h0, irq_o});
    wr(PCC_OVF_CLR_ADDR, 64'h1_0000_0005);
    rd("st_part", PCC_GLB_STAT_ADDR, 64'ha);
    rd("ovf_clr_rd", PCC_OVF_CLR_ADDR, 64'h0);
    rd("unmapped", 16'h03ff, 64'h0);
    // Reset in mid-run wipes flags and controls
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd("st_rst2", PCC_GLB_STAT_ADDR, 64'h0);
    rd("mask_rst2", PCC_IRQ_MASK_ADDR, 64'h0);
    tally_and_finish();
  end
endmodule : pcc_top_tb_top
